// File: common/cmj_pkg.sv
// Constants, encodings and types of the command state and join status front end.
// Assumes a 40 MHz system clock; the serial bytes arrive already deframed.
package cmj_pkg;

    // Time base
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int MS_PER_IDLE_UNIT = 100;

    // Setting reset values and legal ranges
    localparam logic [15:0] IDLE_TIMEOUT_RST = 16'h0064;
    localparam logic [15:0] IDLE_TIMEOUT_MIN = 16'h0002;
    localparam logic [15:0] IDLE_TIMEOUT_MAX = 16'h028f;
    localparam logic [15:0] GUARD_TIME_RST = 16'h03e8;
    localparam logic [15:0] GUARD_TIME_MIN = 16'h0001;
    localparam logic [15:0] GUARD_TIME_MAX = 16'h0ce4;
    localparam logic [7:0] ESC_CHAR_RST = 8'h2b;
    localparam int ESC_COUNT = 3;

    // Firmware version fields: digits ABC release, B variant, D revision
    localparam int FW_REV_LSB = 0;
    localparam int FW_VARIANT_LSB = 8;
    localparam int FW_RELEASE_LSB = 4;
    // Hardware version fields
    localparam int HW_REV_LSB = 0;
    localparam int HW_TYPE_LSB = 8;

    // Join status codes
    localparam logic [7:0] JS_JOINED = 8'h00;
    localparam logic [7:0] JS_NO_PAN = 8'h21;
    localparam logic [7:0] JS_NO_VALID_PAN = 8'h22;
    localparam logic [7:0] JS_PERMIT_CLOSED = 8'h23;
    localparam logic [7:0] JS_NO_BEACON = 8'h24;
    localparam logic [7:0] JS_BAD_STATE = 8'h25;
    localparam logic [7:0] JS_JOIN_FAIL = 8'h27;
    localparam logic [7:0] JS_COORD_FAIL = 8'h2a;
    localparam logic [7:0] JS_COORD_CHECK = 8'h2b;
    localparam logic [7:0] JS_LEAVE_FAIL = 8'h2c;
    localparam logic [7:0] JS_NO_RESPONSE = 8'hab;
    localparam logic [7:0] JS_KEY_UNSECURED = 8'hac;
    localparam logic [7:0] JS_KEY_MISSING = 8'haf;
    localparam logic [7:0] JS_LINK_KEY = 8'haf;
    localparam logic [7:0] JS_SCANNING = 8'hff;
    localparam logic [7:0] JOIN_STATUS_RST = 8'hff;

    typedef enum logic [3:0] {
        CMD_RD_FW, CMD_RD_HW, CMD_RD_JOIN, CMD_RD_IDLE, CMD_WR_IDLE, CMD_RD_GUARD,
        CMD_WR_GUARD, CMD_RD_ESC, CMD_WR_ESC, CMD_LEAVE
    } cmj_cmd_t;

    typedef enum logic [3:0] {
        RES_OK, RES_NO_PAN, RES_NO_VALID_PAN, RES_PERMIT_CLOSED, RES_NO_BEACON, RES_BAD_STATE,
        RES_JOIN_FAIL, RES_COORD_FAIL, RES_COORD_CHECK, RES_LEAVE_FAIL, RES_NO_RESPONSE,
        RES_KEY_UNSECURED, RES_KEY_MISSING, RES_LINK_KEY
    } cmj_join_res_t;

    typedef enum logic [2:0] {
        ST_DATA, ST_ESC1, ST_ESC2, ST_POST, ST_CMD
    } cmj_state_t;

endpackage : cmj_pkg

// File: common/cmj_tick_if.sv
// Carries the 1 ms and 100 ms enable pulses from the time base to the front end.
// Both pulses are one system clock wide.
`timescale 1ns/1ps
interface cmj_tick_if;
    logic tick_ms;
    logic tick_100ms;
    modport src (output tick_ms, output tick_100ms);
    modport snk (input tick_ms, input tick_100ms);
endinterface : cmj_tick_if

// File: logic/cmj_tick_gen.sv
// Time base: divides the system clock into 1 ms and 100 ms enable pulses.
// Assumes srst synchronous to clk_sys.
`timescale 1ns/1ps
module cmj_tick_gen import cmj_pkg::*; #(
    parameter int CYC_MS = CYC_PER_MS
) (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    cmj_tick_if.src ticks // Enable pulses out
);
    typedef struct packed {
        logic [31:0] cyc;
        logic [7:0] ms;
        logic tick_ms;
        logic tick_100ms;
    } cmj_tick_state_t;

    cmj_tick_state_t r, next_r;

    always_comb begin
        next_r = r;
        next_r.tick_ms = 1'b0;
        next_r.tick_100ms = 1'b0;
        if (r.cyc == 32'(CYC_MS - 1)) begin
            next_r.cyc = 32'h0;
            next_r.tick_ms = 1'b1;
            if (r.ms == 8'(MS_PER_IDLE_UNIT - 1)) begin
                next_r.ms = 8'h0;
                next_r.tick_100ms = 1'b1;
            end else begin
                next_r.ms = r.ms + 8'h1;
            end
        end else begin
            next_r.cyc = r.cyc + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign ticks.tick_ms = r.tick_ms;
    assign ticks.tick_100ms = r.tick_100ms;

    a_ms_spacing: assert property (@(posedge clk_sys) disable iff (srst)
        r.tick_100ms |-> r.tick_ms)
        else $error("100 ms pulse without 1 ms pulse");
endmodule : cmj_tick_gen

// File: logic/cmj_command_front.sv
// Serial command state front end: guarded escape entry, idle timeout and explicit
// leave, version and join status reporting, and the three command state settings.
// Assumes deframed serial bytes and decoded commands, all synchronous to clk_sys.
//
// Contract
// - Firmware version: sixteen bits, four hex digits
// - Hardware version: upper type, lower revision
// - Join status zero after forming or joining
// - Distinct codes for each scan failure kind
// - Code for parents found, joining closed
// - Codes for bad state, failed join
// - Codes for coordinator start, check, leave
// - Codes for secure join errors
// - All ones status while scanning
// - Idle timeout leaves command state, 100 ms units
// - Leave command exits command state immediately
// - Guard silence before and after escapes, ms
// - Enter only on guard, escapes, guard
// - Escape character programmable, default plus sign
// - Escape entry only in transparent variants
`timescale 1ns/1ps
module cmj_command_front import cmj_pkg::*; #(
    parameter int CYC_MS = CYC_PER_MS,
    parameter logic [11:0] FW_RELEASE = 12'h123, // Arbitrary value
    parameter logic [3:0] FW_REVISION = 4'h4, // Arbitrary value
    parameter logic [7:0] HW_TYPE = 8'h5a, // Arbitrary value
    parameter logic [7:0] HW_REVISION = 8'h01 // Arbitrary value
) (
    input wire logic clk_sys, // System clock, 40 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic framed_variant, // High in framed-packet variants
    input wire logic rx_valid, // Host byte strobe
    input wire logic [7:0] rx_byte, // Host byte
    input wire logic cmd_valid, // Decoded valid command strobe
    input wire logic [3:0] cmd_code, // Command selector
    input wire logic [15:0] cmd_wdata, // Write value
    input wire logic join_scanning, // Network stack is scanning
    input wire logic join_event, // Join procedure finished
    input wire logic [3:0] join_result, // Outcome of that procedure
    output logic command_state, // In command state
    output logic rsp_valid, // Answer strobe
    output logic rsp_error, // Answer is a refusal
    output logic [15:0] rsp_data, // Answer value
    output logic [7:0] join_status_code, // Current join status
    output logic [15:0] command_idle_timeout, // Idle timeout setting
    output logic [15:0] guard_silence_time, // Guard time setting
    output logic [7:0] escape_character // Escape character setting
);
    localparam logic [15:0] FIRMWARE_VERSION = {FW_RELEASE, FW_REVISION};
    localparam logic [15:0] HARDWARE_VERSION = {HW_TYPE, HW_REVISION};
    localparam logic [11:0] QUIET_MAX = 12'hfff;

    typedef struct packed {
        cmj_state_t st;
        logic [11:0] quiet;
        logic [15:0] idle;
        logic [15:0] idle_timeout;
        logic [15:0] guard_time;
        logic [7:0] esc_char;
        logic [7:0] join_status;
        logic command_state;
        logic rsp_valid;
        logic rsp_error;
        logic [15:0] rsp_data;
    } cmj_front_state_t;

    cmj_front_state_t r, next_r;
    cmj_tick_if ticks ();

    cmj_tick_gen #(
        .CYC_MS(CYC_MS)
    ) u_tick (
        .clk_sys(clk_sys),
        .srst(srst),
        .ticks(ticks)
    );

    cmj_cmd_t cmd;
    logic quiet_met;
    logic is_esc;
    logic [7:0] result_code;

    assign cmd = cmj_cmd_t'(cmd_code);
    // Silence counted in whole ticks, so real silence is between guard-1 and guard ms
    assign quiet_met = {4'h0, r.quiet} >= r.guard_time;
    assign is_esc = rx_byte == r.esc_char;

    always_comb begin
        case (cmj_join_res_t'(join_result))
            RES_OK: result_code = JS_JOINED;
            RES_NO_PAN: result_code = JS_NO_PAN;
            RES_NO_VALID_PAN: result_code = JS_NO_VALID_PAN;
            RES_NO_BEACON: result_code = JS_NO_BEACON;
            RES_PERMIT_CLOSED: result_code = JS_PERMIT_CLOSED;
            RES_BAD_STATE: result_code = JS_BAD_STATE;
            RES_JOIN_FAIL: result_code = JS_JOIN_FAIL;
            RES_COORD_FAIL: result_code = JS_COORD_FAIL;
            RES_COORD_CHECK: result_code = JS_COORD_CHECK;
            RES_LEAVE_FAIL: result_code = JS_LEAVE_FAIL;
            RES_NO_RESPONSE: result_code = JS_NO_RESPONSE;
            RES_KEY_UNSECURED: result_code = JS_KEY_UNSECURED;
            RES_KEY_MISSING: result_code = JS_KEY_MISSING;
            RES_LINK_KEY: result_code = JS_LINK_KEY;
            // Unknown outcome must never read as success
            default: result_code = JS_BAD_STATE;
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.rsp_valid = 1'b0;
        next_r.rsp_error = 1'b0;

        // Silence since the last host byte, saturating
        if (rx_valid) begin
            next_r.quiet = 12'h0;
        end else if (ticks.tick_ms && r.quiet != QUIET_MAX) begin
            next_r.quiet = r.quiet + 12'h1;
        end

        // Scanning overrides any finished outcome
        if (join_scanning) begin
            next_r.join_status = JS_SCANNING;
        end else if (join_event) begin
            next_r.join_status = result_code;
        end

        case (r.st)
            ST_DATA: begin
                if (rx_valid && is_esc && quiet_met && !framed_variant) begin
                    next_r.st = ST_ESC1;
                end
            end
            ST_ESC1, ST_ESC2: begin
                if (rx_valid) begin
                    if (is_esc) begin
                        next_r.st = (r.st == ST_ESC1) ? ST_ESC2 : ST_POST;
                    end else begin
                        next_r.st = ST_DATA;
                    end
                end else if (quiet_met || framed_variant) begin
                    next_r.st = ST_DATA;
                end
            end
            ST_POST: begin
                if (rx_valid || framed_variant) begin
                    next_r.st = ST_DATA;
                end else if (quiet_met) begin
                    next_r.st = ST_CMD;
                    next_r.command_state = 1'b1;
                    next_r.idle = 16'h0;
                end
            end
            ST_CMD: begin
                if (cmd_valid) begin
                    next_r.idle = 16'h0;
                    next_r.rsp_valid = 1'b1;
                    next_r.rsp_data = 16'h0;
                    case (cmd)
                        CMD_RD_FW: next_r.rsp_data = FIRMWARE_VERSION;
                        CMD_RD_HW: next_r.rsp_data = HARDWARE_VERSION;
                        CMD_RD_JOIN: next_r.rsp_data = {8'h0, r.join_status};
                        CMD_RD_IDLE: next_r.rsp_data = r.idle_timeout;
                        CMD_RD_GUARD: next_r.rsp_data = r.guard_time;
                        CMD_RD_ESC: next_r.rsp_data = {8'h0, r.esc_char};
                        CMD_WR_IDLE: begin
                            if (cmd_wdata >= IDLE_TIMEOUT_MIN && cmd_wdata <= IDLE_TIMEOUT_MAX) begin
                                next_r.idle_timeout = cmd_wdata;
                            end else begin
                                next_r.rsp_error = 1'b1;
                            end
                        end
                        CMD_WR_GUARD: begin
                            if (cmd_wdata >= GUARD_TIME_MIN && cmd_wdata <= GUARD_TIME_MAX) begin
                                next_r.guard_time = cmd_wdata;
                            end else begin
                                next_r.rsp_error = 1'b1;
                            end
                        end
                        CMD_WR_ESC: begin
                            if (framed_variant) begin
                                next_r.rsp_error = 1'b1;
                            end else begin
                                next_r.esc_char = cmd_wdata[7:0];
                            end
                        end
                        CMD_LEAVE: begin
                            next_r.st = ST_DATA;
                            next_r.command_state = 1'b0;
                        end
                        default: next_r.rsp_error = 1'b1;
                    endcase
                end else if (r.idle >= r.idle_timeout) begin
                    next_r.st = ST_DATA;
                    next_r.command_state = 1'b0;
                end else if (ticks.tick_100ms) begin
                    next_r.idle = r.idle + 16'h1;
                end
            end
            default: begin
                next_r.st = ST_DATA;
                next_r.command_state = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            r <= '0;
            r.st <= ST_DATA;
            r.idle_timeout <= IDLE_TIMEOUT_RST;
            r.guard_time <= GUARD_TIME_RST;
            r.esc_char <= ESC_CHAR_RST;
            r.join_status <= JOIN_STATUS_RST;
        end else begin
            r <= next_r;
        end
    end

    assign command_state = r.command_state;
    assign rsp_valid = r.rsp_valid;
    assign rsp_error = r.rsp_error;
    assign rsp_data = r.rsp_data;
    assign join_status_code = r.join_status;
    assign command_idle_timeout = r.idle_timeout;
    assign guard_silence_time = r.guard_time;
    assign escape_character = r.esc_char;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    a_fw_answer: assert property (
        r.st == ST_CMD && cmd_valid && cmd == CMD_RD_FW |=> rsp_valid && !rsp_error && rsp_data == FIRMWARE_VERSION)
        else $error("Firmware version answer wrong");

    a_hw_answer: assert property (
        r.st == ST_CMD && cmd_valid && cmd == CMD_RD_HW |=> rsp_valid && rsp_data[15:8] == HW_TYPE
            && rsp_data[7:0] == HW_REVISION)
        else $error("Hardware version answer wrong");

    a_join_success: assert property (
        !join_scanning && join_event && join_result == 4'(RES_OK) |=> join_status_code == 8'h00)
        else $error("Join success not reported as zero");

    a_scan_code: assert property (
        !join_scanning && join_event && join_result == 4'(RES_NO_PAN) |=> join_status_code == 8'h21)
        else $error("No network code wrong");

    a_scan_hold: assert property (
        join_scanning [*2] |=> join_status_code == 8'hff)
        else $error("Status not all ones while scanning");

    a_timeout_exit: assert property (
        r.st == ST_CMD && !cmd_valid && r.idle >= r.idle_timeout |=> !command_state ##1 !command_state)
        else $error("Idle timeout did not leave command state");

    a_leave_exit: assert property (
        r.st == ST_CMD && cmd_valid && cmd == CMD_LEAVE |=> !command_state && rsp_valid)
        else $error("Leave command not immediate");

    a_enter_guard: assert property (
        $rose(command_state) |-> $past(r.st) == ST_POST && $past(quiet_met) && !$past(rx_valid))
        else $error("Command state entered without full sequence");

    a_variant_block: assert property (
        framed_variant && r.st == ST_DATA |=> r.st == ST_DATA)
        else $error("Escape entry in framed variant");

    a_other_abort: assert property (
        (r.st == ST_ESC1 || r.st == ST_ESC2) && rx_valid && !is_esc |=> r.st == ST_DATA)
        else $error("Foreign byte did not abort escape");

    a_idle_restart: assert property (
        r.st == ST_CMD && cmd_valid && cmd != CMD_LEAVE |=> r.idle == 16'h0 && command_state)
        else $error("Idle timer not restarted");

    a_guard_range: assert property (
        guard_silence_time >= GUARD_TIME_MIN && guard_silence_time <= GUARD_TIME_MAX)
        else $error("Guard time out of range");

    a_permit_code: assert property (
        !join_scanning && join_event && join_result == 4'(RES_PERMIT_CLOSED)
        |=> join_status_code == 8'h23)
        else $error("Joining closed code wrong");

    a_fail_code: assert property (
        !join_scanning && join_event && join_result == 4'(RES_JOIN_FAIL)
        |=> join_status_code == 8'h27)
        else $error("Join failure code wrong");

    a_coord_code: assert property (
        !join_scanning && join_event && join_result == 4'(RES_COORD_FAIL)
        |=> join_status_code == 8'h2a)
        else $error("Coordinator start code wrong");

    a_secure_code: assert property (
        !join_scanning && join_event && join_result == 4'(RES_NO_RESPONSE)
        |=> join_status_code == 8'hab)
        else $error("Secure join code wrong");

    a_scan_wins: assert property (
        join_scanning
        |=> join_status_code == 8'hff)
        else $error("Scanning did not win over outcome");

    a_idle_count: assert property (
        r.st == ST_CMD && !cmd_valid && r.idle < r.idle_timeout
        |=> command_state)
        else $error("Command state left before timeout");

    a_cmd_ignored: assert property (
        r.st != ST_CMD && cmd_valid
        |=> !rsp_valid)
        else $error("Command answered outside command state");

    a_esc_entry: assert property (
        r.st == ST_DATA && rx_valid && !quiet_met
        |=> r.st == ST_DATA)
        else $error("Escape entry without leading silence");

    a_esc_write: assert property (
        r.st == ST_CMD && cmd_valid && cmd == CMD_WR_ESC && !framed_variant
        |=> escape_character == $past(cmd_wdata[7:0]))
        else $error("Escape character not written");

    a_esc_refused: assert property (
        r.st == ST_CMD && cmd_valid && cmd == CMD_WR_ESC && framed_variant
        |=> rsp_error && $stable(escape_character))
        else $error("Escape character write not refused");

    a_gap_abort: assert property (
        (r.st == ST_ESC1 || r.st == ST_ESC2) && !rx_valid && quiet_met
        |=> r.st == ST_DATA)
        else $error("Gap did not abort escape");

    a_post_abort: assert property (
        r.st == ST_POST && rx_valid
        |=> r.st == ST_DATA)
        else $error("Byte after escapes did not abort");
endmodule : cmj_command_front

// File: tb/cmj_host_model.sv
// Host model: drives serial bytes and decoded commands into the front end.
// Assumes stimulus changes 1 ns after the rising edge of clk_sys.
`timescale 1ns/1ps
module cmj_host_model (
    input wire logic clk_sys, // System clock
    output logic rx_valid, // Byte strobe
    output logic [7:0] rx_byte, // Byte
    output logic cmd_valid, // Command strobe
    output logic [3:0] cmd_code, // Selector
    output logic [15:0] cmd_wdata // Write value
);
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        cmd_valid = 1'b0;
        cmd_code = 4'h0;
        cmd_wdata = 16'h0000;
    end

    task automatic send_byte(input logic [7:0] b);
        @(posedge clk_sys);
        #1;
        rx_valid = 1'b1;
        rx_byte = b;
        @(posedge clk_sys);
        #1;
        rx_valid = 1'b0;
        rx_byte = ~b; // Released line never repeats the byte
    endtask : send_byte

    task automatic esc_seq(input logic [7:0] c, input int n, input int lead, input int tail);
        repeat (lead) @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            send_byte(c);
        end
        repeat (tail) @(posedge clk_sys);
        #1;
    endtask : esc_seq

    task automatic command(input logic [3:0] c, input logic [15:0] d);
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_wdata = d;
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b0;
        cmd_code = ~c;
        cmd_wdata = ~d;
    endtask : command
endmodule : cmj_host_model

// File: tb/tb_top.sv
// Self-checking bench for the command state and join status front end.
// Assumes a 40 MHz clk_sys; 1 ms is shortened to 10 cycles to keep the run short.
`timescale 1ns/1ps
module tb_top;
    import cmj_pkg::*;
    localparam int CYC = 10;
    localparam logic [11:0] FWR = 12'h7e3; // Arbitrary value
    localparam logic [3:0] FWV = 4'h9; // Arbitrary value
    localparam logic [7:0] HWT = 8'h3c; // Arbitrary value
    localparam logic [7:0] HWR = 8'h05; // Arbitrary value
    logic clk_sys, srst, framed_variant, join_scanning, join_event;
    logic rx_valid, cmd_valid, command_state, rsp_valid, rsp_error;
    logic [3:0] join_result, cmd_code;
    logic [7:0] rx_byte, join_status_code, escape_character;
    logic [15:0] cmd_wdata, rsp_data, command_idle_timeout, guard_silence_time;
    logic [7:0] jexp [15] = '{8'h00, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h27, 8'h2a, 8'h2b, 8'h2c,
                              8'hab, 8'hac, 8'haf, 8'haf, 8'h25};
    int errors = 0;
    int n_compared = 0;

    cmj_command_front #(.CYC_MS(CYC), .FW_RELEASE(FWR), .FW_REVISION(FWV), .HW_TYPE(HWT),
        .HW_REVISION(HWR)) dut_u (.clk_sys(clk_sys), .srst(srst), .framed_variant(framed_variant),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .join_scanning(join_scanning), .join_event(join_event),
        .join_result(join_result), .command_state(command_state), .rsp_valid(rsp_valid),
        .rsp_error(rsp_error), .rsp_data(rsp_data), .join_status_code(join_status_code),
        .command_idle_timeout(command_idle_timeout), .guard_silence_time(guard_silence_time),
        .escape_character(escape_character));

    cmj_host_model host_u (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic cmd_chk(input logic [3:0] c, input logic [15:0] d, input logic err, input logic [15:0] exp);
        host_u.command(c, d);
        chk(rsp_valid, 1'b1);
        chk(rsp_error, err);
        if (!err) begin
            chk(rsp_data, exp);
        end
    endtask : cmd_chk

    // Bounded wait, so a missing transition reports instead of hanging
    task automatic wait_cs(input logic v, input int lim);
        for (int i = 0; i < lim && command_state !== v; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk(command_state, v);
    endtask : wait_cs

    task automatic enter(input int g);
        host_u.esc_seq(escape_character, 3, g + 3 * CYC, g / 2);
        chk(command_state, 1'b0);
        wait_cs(1'b1, g + 3 * CYC);
    endtask : enter

    task automatic t_reset;
        chk(command_state, 1'b0);
        chk(command_idle_timeout, 16'h0064);
        chk(guard_silence_time, 16'h03e8);
        chk(escape_character, 8'h2b);
        host_u.command(CMD_RD_FW, 16'h0000);
        chk(rsp_valid, 1'b0);
    endtask : t_reset

    task automatic t_regs;
        cmd_chk(CMD_RD_FW, 16'h0000, 1'b0, {FWR, FWV});
        cmd_chk(CMD_RD_HW, 16'h0000, 1'b0, {HWT, HWR});
        cmd_chk(CMD_WR_IDLE, 16'h0001, 1'b1, 16'h0000);
        cmd_chk(CMD_WR_IDLE, 16'h0290, 1'b1, 16'h0000);
        cmd_chk(CMD_RD_IDLE, 16'h0000, 1'b0, 16'h0064);
        cmd_chk(CMD_WR_IDLE, 16'h028f, 1'b0, 16'h0000);
        cmd_chk(CMD_RD_IDLE, 16'h0000, 1'b0, 16'h028f);
        cmd_chk(CMD_WR_GUARD, 16'h0000, 1'b1, 16'h0000);
        cmd_chk(CMD_WR_GUARD, 16'h0ce5, 1'b1, 16'h0000);
        cmd_chk(CMD_WR_GUARD, 16'h0ce4, 1'b0, 16'h0000);
        cmd_chk(CMD_RD_GUARD, 16'h0000, 1'b0, 16'h0ce4);
        cmd_chk(CMD_WR_GUARD, 16'h0002, 1'b0, 16'h0000);
        chk(guard_silence_time, 16'h0002);
        framed_variant = 1'b1;
        cmd_chk(CMD_WR_ESC, 16'h0021, 1'b1, 16'h0000);
        chk(escape_character, 8'h2b);
        framed_variant = 1'b0;
        cmd_chk(CMD_WR_ESC, 16'h1221, 1'b0, 16'h0000);
        cmd_chk(CMD_RD_ESC, 16'h0000, 1'b0, 16'h0021);
        cmd_chk(4'hb, 16'h0000, 1'b1, 16'h0000);
    endtask : t_regs

    task automatic t_join;
        for (int i = 0; i < 15; i++) begin
            @(posedge clk_sys);
            #1;
            join_event = 1'b1;
            join_result = i[3:0];
            @(posedge clk_sys);
            #1;
            join_event = 1'b0;
            join_result = ~i[3:0];
            chk(join_status_code, jexp[i]);
            cmd_chk(CMD_RD_JOIN, 16'h0000, 1'b0, {8'h00, jexp[i]});
        end
        join_scanning = 1'b1;
        join_event = 1'b1;
        join_result = 4'h0;
        @(posedge clk_sys);
        #1;
        join_event = 1'b0;
        chk(join_status_code, 8'hff);
        for (int k = 0; k < 4; k++) begin
            if (k == 2) begin
                join_scanning = 1'b0;
                join_event = 1'b1;
                @(posedge clk_sys);
                #1;
                join_event = 1'b0;
            end
            host_u.command(CMD_RD_JOIN, 16'h0000);
            if (rsp_data === 16'h0000) begin
                break;
            end
            chk(rsp_data, 16'h00ff);
        end
        chk(rsp_data, 16'h0000);
    endtask : t_join

    task automatic t_leave;
        host_u.command(CMD_LEAVE, 16'h0000);
        chk(rsp_valid, 1'b1);
        chk(command_state, 1'b0);
        host_u.command(CMD_RD_FW, 16'h0000);
        chk(rsp_valid, 1'b0);
    endtask : t_leave

    task automatic t_abort;
        host_u.esc_seq(8'h21, 2, 6 * CYC, 0);
        host_u.esc_seq(8'h61, 1, 0, 8 * CYC);
        chk(command_state, 1'b0);
        host_u.esc_seq(8'h21, 4, 6 * CYC, 8 * CYC);
        chk(command_state, 1'b0);
        host_u.esc_seq(8'h21, 1, 6 * CYC, 6 * CYC);
        host_u.esc_seq(8'h21, 2, 0, 8 * CYC);
        chk(command_state, 1'b0);
        framed_variant = 1'b1;
        host_u.esc_seq(8'h21, 3, 6 * CYC, 8 * CYC);
        chk(command_state, 1'b0);
        framed_variant = 1'b0;
    endtask : t_abort

    task automatic t_timeout;
        enter(2 * CYC);
        cmd_chk(CMD_WR_IDLE, 16'h0003, 1'b0, 16'h0000);
        repeat (190 * CYC) @(posedge clk_sys);
        #1;
        chk(command_state, 1'b1);
        host_u.command(CMD_RD_HW, 16'h0000);
        repeat (190 * CYC) @(posedge clk_sys);
        #1;
        chk(command_state, 1'b1);
        repeat (120 * CYC) @(posedge clk_sys);
        #1;
        chk(command_state, 1'b0);
    endtask : t_timeout

    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        srst = 1'b1;
        framed_variant = 1'b0;
        join_scanning = 1'b0;
        join_event = 1'b0;
        join_result = 4'h0;
        repeat (5) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        t_reset();
        enter(1000 * CYC);
        t_regs();
        t_join();
        t_leave();
        t_abort();
        t_timeout();
        stop_test();
    end
endmodule : tb_top
